// ==== rtl/bit_test_branch_subroutine.sv ====
// decode and execute of the branch-to-subroutine-if-bit-one instruction
// assumes: core hands instruction, extension word and next pc with start;
// operand, pointer update and stack units sit on the same clock
//
// Behaviour
// - taken pushes next address high, status low
// - taken loads pc plus 32-bit displacement
// - displacement base is following instruction address
// - bit zero: no push, pc advances sequentially
// - pointer post-modification happens regardless of outcome
// - stack high source decrements pointer, push overwrites
// - five-bit immediate picks tested bit 0-31
// - condition, exception and sticky status untouched
// - short io form: 1110, one, 7-bit address
// - absolute short form: 1110, zero, 7-bit address
// - ea form 1100, indirect modes only, no displacement
// - register form 1111 with 7-bit selector
// - two words, eight cycles plus jump wait
`timescale 1ns/10ps
`default_nettype none
`include "bsub_defines.svh"

module bit_test_branch_subroutine
   import bsub_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   // instruction from the program controller
   input wire logic start,
   input wire logic [31:0] instr_word,
   input wire logic [31:0] ext_word,
   input wire logic [31:0] pc_following,
   input wire logic [31:0] status_word,
   input wire logic jump_wait,
   // operand fetch
   output operand_req_s op_req,
   output logic op_req_valid,
   input wire logic op_valid,
   input wire logic [31:0] op_data,
   // side effects
   output logic ptr_update,
   output logic [2:0] ptr_update_mode,
   output logic [2:0] ptr_update_rnum,
   output logic stack_pointer_dec,
   output logic push_valid,
   output stack_push_s push_data,
   // result
   output logic done,
   output logic taken,
   output logic illegal,
   output logic pc_load,
   output logic [31:0] pc_value
);

   bsub_state_e state_reg;
   operand_req_s req_next;
   logic legal_next;
   logic [4:0] bitnum_reg;
   logic [31:0] disp_reg;
   logic [31:0] pc_base_reg;
   logic [31:0] status_reg;
   logic [7:0] cnt_reg;
   logic accept;
   logic fetch_hit;
   logic bit_one;
   logic postmod;
   logic from_stack_high;

   assign accept = clk_en && state_reg == st_idle && start;
   assign fetch_hit = clk_en && state_reg == st_fetch && op_valid && op_req_valid;
   assign bit_one = op_data[bitnum_reg];
   assign postmod = op_req.kind == src_indirect && op_req.mode != `BSUB_MODE_PLAIN
      && op_req.mode != `BSUB_MODE_INDEXED;
   assign from_stack_high = op_req.kind == src_register && op_req.sel == `BSUB_SEL_STACK_HIGH;

   // instruction decode
   always_comb begin
      req_next = '0;
      legal_next = 1'b0;
      req_next.space_y = instr_word[`BSUB_SPACE_BIT];
      req_next.mode = instr_word[`BSUB_MODE_LSB +: 3];
      req_next.rnum = instr_word[`BSUB_RNUM_LSB +: 3];
      req_next.sel = instr_word[`BSUB_ADDR_LSB +: 7];
      if (instr_word[31:24] == `BSUB_OPC_HIGH && instr_word[7:5] == `BSUB_BIT_PAD) begin
         unique case (instr_word[23:20])
            `BSUB_FORM_REG: begin
               req_next.kind = src_register;
               req_next.space_y = 1'b0;
               req_next.sel = instr_word[`BSUB_SEL_LSB +: 7];
               legal_next = instr_word[11:8] == `BSUB_REG_TAIL && !instr_word[12]
                  && (!req_next.sel[6] || req_next.sel >= `BSUB_SEL_CTRL_FIRST);
            end
            `BSUB_FORM_SHORT: begin
               req_next.kind = instr_word[`BSUB_IO_BIT] ? src_io : src_absolute;
               legal_next = instr_word[11:9] == `BSUB_MEM_TAIL;
            end
            `BSUB_FORM_EA: begin
               req_next.kind = src_indirect;
               req_next.sel = '0;
               legal_next = instr_word[11:9] == `BSUB_MEM_TAIL && instr_word[13:12] == 2'h0
                  && req_next.mode != `BSUB_MODE_DISP;
            end
            default: legal_next = 1'b0;
         endcase
      end
   end

   // sequencing
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= st_idle;
      end else if (clk_en) begin
         unique case (state_reg)
            st_idle: if (start) state_reg <= legal_next ? st_fetch : st_wait;
            st_fetch: if (op_valid && op_req_valid) state_reg <= st_wait;
            st_wait: if (cnt_reg >= `BSUB_MIN_CYCLES - 8'h01 && !jump_wait) state_reg <= st_idle;
         endcase
      end
   end

   // cycle count from start
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 8'h00;
      end else if (clk_en) begin
         if (accept) cnt_reg <= 8'h01;
         else if (state_reg != st_idle && cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
      end
   end

   // captured instruction context
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         op_req <= '0;
         bitnum_reg <= 5'h00;
         disp_reg <= 32'h00000000;
         pc_base_reg <= 32'h00000000;
         status_reg <= 32'h00000000;
         illegal <= 1'b0;
      end else if (accept) begin
         op_req <= req_next;
         bitnum_reg <= instr_word[`BSUB_BITNUM_LSB +: 5];
         disp_reg <= ext_word;
         pc_base_reg <= pc_following;
         status_reg <= status_word;
         illegal <= !legal_next;
      end
   end

   // operand request handshake
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         op_req_valid <= 1'b0;
      end else if (clk_en) begin
         if (accept) op_req_valid <= legal_next;
         else if (fetch_hit) op_req_valid <= 1'b0;
      end
   end

   // execute: test, push, pointer and stack side effects
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         taken <= 1'b0;
         push_valid <= 1'b0;
         push_data <= '0;
         ptr_update <= 1'b0;
         ptr_update_mode <= 3'h0;
         ptr_update_rnum <= 3'h0;
         stack_pointer_dec <= 1'b0;
         pc_value <= 32'h00000000;
      end else if (clk_en) begin
         push_valid <= 1'b0;
         ptr_update <= 1'b0;
         stack_pointer_dec <= 1'b0;
         if (accept) begin
            taken <= 1'b0;
         end else if (fetch_hit) begin
            taken <= bit_one;
            push_valid <= bit_one;
            push_data.stack_high_word <= pc_base_reg;
            push_data.stack_low_word <= status_reg;
            ptr_update <= postmod;
            ptr_update_mode <= op_req.mode;
            ptr_update_rnum <= op_req.rnum;
            stack_pointer_dec <= from_stack_high;
            pc_value <= bit_one ? pc_base_reg + disp_reg : pc_base_reg;
         end
      end
   end

   // completion
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         done <= 1'b0;
         pc_load <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         pc_load <= 1'b0;
         if (state_reg == st_wait && cnt_reg >= `BSUB_MIN_CYCLES - 8'h01 && !jump_wait) begin
            done <= 1'b1;
            pc_load <= !illegal;
         end
      end
   end

   // checks
   logic pushed_reg;
   logic [31:0] pc_target;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pushed_reg <= 1'b0;
      end else if (clk_en) begin
         if (accept) pushed_reg <= 1'b0;
         else if (push_valid) pushed_reg <= 1'b1;
      end
   end
   assign pc_target = pc_base_reg + disp_reg;

   sequence fetch_s;
      fetch_hit && postmod;
   endsequence

   sequence finish_s;
      done && pc_load;
   endsequence

   push_content_check_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      push_valid |-> push_data.stack_high_word == pc_base_reg
         && push_data.stack_low_word == status_reg)
      else $error("push carries wrong words");

   taken_target_check_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      finish_s and taken |-> pc_value == pc_target)
      else $error("taken target wrong");

   base_capture_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      accept |=> pc_base_reg == $past(pc_following))
      else $error("pc base not following address");

   fall_through_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      finish_s and !taken |-> !pushed_reg && pc_value == pc_base_reg)
      else $error("fall through pushed or jumped");

   ptr_always_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      fetch_s |=> ptr_update ##1 !ptr_update)
      else $error("pointer update missing");

   stack_overwrite_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      fetch_hit && from_stack_high |=> stack_pointer_dec && (push_valid == taken))
      else $error("stack high source mishandled");

   bit_select_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      fetch_hit |=> taken == $past(op_data[bitnum_reg]))
      else $error("wrong bit tested");

   reject_disp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      accept && instr_word[31:20] == 12'h02C && instr_word[19:17] == `BSUB_MODE_DISP
         |=> illegal && !op_req_valid)
      else $error("displacement mode accepted");

   min_cycles_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      done |-> cnt_reg >= `BSUB_MIN_CYCLES)
      else $error("instruction shorter than eight cycles");

endmodule // bit_test_branch_subroutine

`default_nettype wire

// ==== rtl/bsub_defines.svh ====
// constants for the bit-test branch-to-subroutine decoder
// assumes: included by bare name, 32-bit instruction words
`ifndef BSUB_DEFINES_SVH
`define BSUB_DEFINES_SVH

// fixed opcode bits 31:24 and form nibble 23:20
`define BSUB_OPC_HIGH 8'h02
`define BSUB_FORM_REG 4'hF
`define BSUB_FORM_SHORT 4'hE
`define BSUB_FORM_EA 4'hC
// bits 11:8 for register form, 11:9 for memory forms, 7:5 always
`define BSUB_REG_TAIL 4'hC
`define BSUB_MEM_TAIL 3'h6
`define BSUB_BIT_PAD 3'h0
// field positions
`define BSUB_BITNUM_LSB 0
`define BSUB_SPACE_BIT 8
`define BSUB_IO_BIT 19
`define BSUB_SEL_LSB 13
`define BSUB_ADDR_LSB 12
`define BSUB_MODE_LSB 17
`define BSUB_RNUM_LSB 14
// register selectors
`define BSUB_SEL_STATUS 7'h79
`define BSUB_SEL_STACK_HIGH 7'h7C
`define BSUB_SEL_CTRL_FIRST 7'h79
// effective address modes
`define BSUB_MODE_PLAIN 3'h4
`define BSUB_MODE_INDEXED 3'h5
`define BSUB_MODE_DISP 3'h6
// least instruction length in oscillator cycles
`define BSUB_MIN_CYCLES 8'h08
`define BSUB_WORDS 32'h00000002

`endif

// ==== rtl/bsub_pkg.sv ====
// types shared by the bit-test branch-to-subroutine decoder
// assumes: nothing beyond the defines header
package bsub_pkg;

   typedef enum logic [1:0] {
      src_register,
      src_absolute,
      src_io,
      src_indirect
   } src_kind_e;

   // operand fetch request to the data path
   typedef struct packed {
      src_kind_e kind;
      logic space_y;
      logic [6:0] sel;
      logic [2:0] mode;
      logic [2:0] rnum;
   } operand_req_s;

   // one push onto the hardware stack
   typedef struct packed {
      logic [31:0] stack_high_word;
      logic [31:0] stack_low_word;
   } stack_push_s;

   typedef enum logic [1:0] {
      st_idle,
      st_fetch,
      st_wait
   } bsub_state_e;

endpackage

// ==== verification/testbench.sv ====
// self-checking bench for the bit-test branch-to-subroutine decoder
// assumes: bsub_pkg compiled first; operand and stack units are played by the bench
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import bsub_pkg::*;

   localparam logic [31:0] PC = 32'h00001234;
   localparam logic [31:0] EXT = 32'hFFFFFFF0;
   localparam logic [31:0] SR = 32'h00A55A0F;

   logic clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1, start = 1'b0, jump_wait = 1'b0;
   logic op_valid = 1'b0;
   logic [31:0] instr_word = 32'h0, ext_word = 32'h0, pc_following = 32'h0;
   logic [31:0] status_word = 32'h0, op_data = 32'h0;
   operand_req_s op_req, r_req;
   stack_push_s push_data, p_dat;
   logic op_req_valid, ptr_update, stack_pointer_dec, push_valid, done, taken, illegal;
   logic pc_load, tk, ill, pl;
   logic [2:0] ptr_update_mode, ptr_update_rnum, u_mode, u_rn;
   logic [31:0] pc_value, pv;
   int n_mismatch = 0, n_tests = 0;
   int d_cyc, p_cnt, p_cyc, u_cnt, s_cnt, s_cyc, r_seen;

   bit_test_branch_subroutine bit_test_branch_subroutine_i (
      .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .start(start),
      .instr_word(instr_word), .ext_word(ext_word), .pc_following(pc_following),
      .status_word(status_word), .jump_wait(jump_wait), .op_req(op_req),
      .op_req_valid(op_req_valid), .op_valid(op_valid), .op_data(op_data),
      .ptr_update(ptr_update), .ptr_update_mode(ptr_update_mode),
      .ptr_update_rnum(ptr_update_rnum), .stack_pointer_dec(stack_pointer_dec),
      .push_valid(push_valid), .push_data(push_data), .done(done), .taken(taken),
      .illegal(illegal), .pc_load(pc_load), .pc_value(pc_value));

   always #2 clk_sys = ~clk_sys;

   function automatic logic [31:0] enc_reg(input logic [6:0] sel, input logic [4:0] b);
      return {8'h02, 4'hF, sel, 1'b0, 4'hC, 3'h0, b};
   endfunction
   function automatic logic [31:0] enc_short(input logic io, input logic [6:0] a,
                                             input logic s, input logic [4:0] b);
      return {8'h02, 4'hE, io, a, 3'h6, s, 3'h0, b};
   endfunction
   function automatic logic [31:0] enc_ea(input logic [2:0] m, input logic [2:0] r,
                                          input logic s, input logic [4:0] b);
      return {8'h02, 4'hC, m, r, 2'h0, 3'h6, s, 3'h0, b};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one instruction; operand answered as soon as it is asked for
   task automatic exec(input logic [31:0] iw, input logic [31:0] dat, input int jw);
      int k;
      logic given;
      begin
         given = 0;
         d_cyc = 0;
         p_cnt = 0;
         u_cnt = 0;
         s_cnt = 0;
         r_seen = 0;
         @(posedge clk_sys);
         start <= 1'b1;
         instr_word <= iw;
         ext_word <= EXT;
         pc_following <= PC;
         status_word <= SR;
         jump_wait <= (jw > 0);
         for (k = 1; k < 40 && d_cyc == 0; k++) begin
            @(posedge clk_sys);
            start <= 1'b0;
            op_valid <= 1'b0;
            if (k == jw) jump_wait <= 1'b0;
            if (op_req_valid === 1'b1 && !given) begin
               given = 1;
               r_seen = 1;
               r_req = op_req;
               op_valid <= 1'b1;
               op_data <= dat;
            end
            if (push_valid === 1'b1) begin
               p_cnt++;
               p_cyc = k;
               p_dat = push_data;
            end
            if (ptr_update === 1'b1) begin
               u_cnt++;
               u_mode = ptr_update_mode;
               u_rn = ptr_update_rnum;
            end
            if (stack_pointer_dec === 1'b1) begin
               s_cnt++;
               s_cyc = k;
            end
            if (done === 1'b1) begin
               d_cyc = k - 1;
               tk = taken;
               pv = pc_value;
               ill = illegal;
               pl = pc_load;
            end
         end
      end
   endtask

   task automatic chk_out(input logic t);
      chk("done_cycle", 8, d_cyc);
      chk("illegal", 0, ill);
      chk("taken", t, tk);
      chk("pc_load", 1, pl);
      chk("push_count", t, p_cnt);
      chk("pc_value", t ? PC + EXT : PC, pv);
      if (t) chk("push_high", PC, p_dat.stack_high_word);
      if (t) chk("push_low", SR, p_dat.stack_low_word);
   endtask

   task automatic t_bits();
      for (int n = 0; n < 32; n++) begin
         exec(enc_reg(7'h05, 5'(n)), 32'h1 << n, 0);
         chk_out(1'b1);
         chk("req_sel", 7'h05, r_req.sel);
         exec(enc_reg(7'h12, 5'(n)), ~(32'h1 << n), 0);
         chk_out(1'b0);
         chk("req_kind", src_register, r_req.kind);
      end
   endtask

   task automatic t_stack();
      for (int t = 0; t < 2; t++) begin
         exec(enc_reg(7'h7C, 5'h3), 32'(t) << 3, 0);
         chk_out(t[0]);
         chk("sp_dec", 1, s_cnt);
         if (t == 1) chk("dec_with_push", s_cyc, p_cyc);
      end
   endtask

   task automatic t_short();
      exec(enc_short(1'b1, 7'h55, 1'b1, 5'h09), 32'h00000200, 0);
      chk_out(1'b1);
      chk("io_req", {src_io, 1'b1, 7'h55}, {r_req.kind, r_req.space_y, r_req.sel});
      exec(enc_short(1'b0, 7'h2A, 1'b0, 5'h1F), 32'h7FFFFFFF, 0);
      chk_out(1'b0);
      chk("abs_req", {src_absolute, 1'b0, 7'h2A},
          {r_req.kind, r_req.space_y, r_req.sel});
   endtask

   task automatic t_ea();
      for (int m = 0; m < 8; m++) begin
         if (m == 6) continue;
         exec(enc_ea(3'(m), 3'(7 - m), m[0], 5'h04), 32'(m % 2) << 4, 0);
         chk_out(m[0]);
         chk("ea_req", {src_indirect, m[0], 3'(m), 3'(7 - m)},
             {r_req.kind, r_req.space_y, r_req.mode, r_req.rnum});
         chk("ptr_count", m < 4 || m == 7, u_cnt);
         if (m < 4 || m == 7) chk("ptr_target", {3'(m), 3'(7 - m)}, {u_mode, u_rn});
      end
   endtask

   task automatic t_illegal();
      logic [31:0] bad [4];
      bad = '{enc_ea(3'h6, 3'h2, 1'b0, 5'h1), enc_reg(7'h40, 5'h1),
              32'h02D00C01, 32'h02F00801};
      for (int i = 0; i < 4; i++) begin
         exec(bad[i], 32'hFFFFFFFF, 0);
         chk("ill_flag", 1, ill);
         chk("ill_quiet", 0, {r_seen[0], p_cnt[0], u_cnt[0], s_cnt[0], pl});
         chk("ill_cycle", 8, d_cyc);
      end
   endtask

   task automatic t_wait();
      exec(enc_reg(7'h79, 5'h02), 32'h00000004, 12);
      chk("wait_done", 1, d_cyc >= 12 && d_cyc <= 13);
      chk("status_src", 1, tk);
      chk("wait_push", 1, p_cnt);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_bits();
      t_stack();
      t_short();
      t_ea();
      t_illegal();
      t_wait();
      close_out();
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      n_mismatch++;
      close_out();
   end
endmodule // testbench

`default_nettype wire
